/* src/pwsq_pkg.sv */
package pwsq_pkg;
   // Clock and timing
   localparam int unsigned CLK_PERIOD_NS  = 10;
   localparam int unsigned CLK_HZ         = 100_000_000;
   localparam int unsigned SVC_LATENCY_NS = 80;   // Controller interrupt service time
   localparam int unsigned SVC_CYC = (SVC_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RESET_HOLD_NS  = 200;
   localparam int unsigned RESET_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned INIT_HOLD_NS   = 200;
   localparam int unsigned INIT_CYC = (INIT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WARN_SEC       = 30;   // Low-battery warning, seconds
   localparam int unsigned SEC_PER_MIN    = 60;
   localparam int unsigned MIN_PER_DAY    = 1440;

   // Widths
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned MIN_W  = 11;
   localparam int unsigned SEC_W  = 6;
   localparam int unsigned TMR_W  = 8;
   localparam int unsigned LIM_W  = 8;

   // Sequencer step ends
   localparam logic [TMR_W-1:0] SVC_LAST   = TMR_W'(SVC_CYC - 1);
   localparam logic [TMR_W-1:0] RESET_LAST = TMR_W'(RESET_CYC - 1);
   localparam logic [TMR_W-1:0] INIT_LAST  = TMR_W'(INIT_CYC - 1);
   localparam logic [SEC_W-1:0] WARN_LAST  = SEC_W'(WARN_SEC - 1);

   // Register map (byte addresses)
   localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] REG_IDLE   = 8'h08;
   localparam logic [ADDR_W-1:0] REG_WAKE   = 8'h0c;
   localparam logic [ADDR_W-1:0] REG_TIME   = 8'h10;

   // Control fields
   localparam int unsigned CTRL_OFF_REQ  = 0;   // Write 1: software power-off, self-clearing
   localparam int unsigned CTRL_WAKE_EN  = 1;
   localparam int unsigned CTRL_AUTO_EN  = 2;
   localparam logic [LIM_W-1:0] IDLE_DEF_MIN = 8'h0a;
   localparam logic             WAKE_EN_RST  = 1'h0;
   localparam logic             AUTO_EN_RST  = 1'h1;

   // Status fields
   localparam int unsigned STAT_ON      = 0;
   localparam int unsigned STAT_LOWBAT  = 1;
   localparam int unsigned STAT_SW      = 2;
   localparam int unsigned STAT_ST_LSB  = 4;
   localparam int unsigned STATE_W      = 3;

   typedef enum logic [STATE_W-1:0] {
      PWSQ_OFF     = 3'b000,
      PWSQ_ON_SVC  = 3'b001,
      PWSQ_PWR_UP  = 3'b010,
      PWSQ_RUN     = 3'b011,
      PWSQ_WARN    = 3'b100,
      PWSQ_OFF_SVC = 3'b101,
      PWSQ_SAVE    = 3'b110,
      PWSQ_INIT    = 3'b111
   } pwsq_state_e;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } pwsq_bus_req_s;

   // One bit per unit: high means unit is unloaded or unpowered
   typedef struct packed {
      logic head_unload;
      logic cassette;
      logic prom;
      logic serial;
      logic barcode;
      logic speaker;
   } pwsq_periph_s;
endpackage

/* src/pwsq_rtc.sv */
`timescale 1ns/1ps
module pwsq_rtc import pwsq_pkg::*; #(
   parameter int unsigned SEC_CYCLES = CLK_HZ
) (
   input  wire logic             i_clk,
   input  wire logic             i_sys_rst,
   input  wire logic             i_time_wr,
   input  wire logic [MIN_W-1:0] i_time_wdata,
   output logic      [MIN_W-1:0] o_minutes,
   output logic                  o_sec_tick,
   output logic                  o_min_tick
);
   localparam int unsigned CW = $clog2(SEC_CYCLES + 1);

   logic [CW-1:0]    cyc;
   logic [SEC_W-1:0] sec;

   // Second and minute boundaries
   wire sec_end = (cyc == CW'(SEC_CYCLES - 1));
   wire min_end = sec_end && (sec == SEC_W'(SEC_PER_MIN - 1));
   wire day_end = (o_minutes == MIN_W'(MIN_PER_DAY - 1));

   // A time write restarts the minute so the first tick is a full minute away
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cyc        <= '0;
         sec        <= '0;
         o_minutes  <= '0;
         o_sec_tick <= 1'b0;
         o_min_tick <= 1'b0;
      end else begin
         o_sec_tick <= sec_end && !i_time_wr;
         o_min_tick <= min_end && !i_time_wr;
         if (i_time_wr) begin
            cyc       <= '0;
            sec       <= '0;
            o_minutes <= i_time_wdata;
         end else begin
            cyc <= sec_end ? '0 : CW'(cyc + 1'b1);
            if (sec_end) sec <= min_end ? '0 : SEC_W'(sec + 1'b1);
            if (min_end) o_minutes <= day_end ? '0 : MIN_W'(o_minutes + 1'b1);
         end
      end
   end
endmodule // pwsq_rtc

/* src/pwsq_idle.sv */
`timescale 1ns/1ps
module pwsq_idle import pwsq_pkg::*; (
   input  wire logic             i_clk,
   input  wire logic             i_sys_rst,
   input  wire logic             i_restart,
   input  wire logic             i_count_en,
   input  wire logic             i_min_tick,
   input  wire logic [LIM_W-1:0] i_limit,
   output logic                  o_timeout
);
   logic [LIM_W-1:0] cnt;

   wire [LIM_W-1:0] next_cnt = LIM_W'(cnt + 1'b1);
   wire             step     = i_count_en && i_min_tick && !i_restart;
   wire             expire   = step && (next_cnt == i_limit);

   // Counts whole minutes of idleness; restart wins over a tick
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt       <= '0;
         o_timeout <= 1'b0;
      end else begin
         o_timeout <= expire;
         if (i_restart || expire) cnt <= '0;
         else if (step) cnt <= next_cnt;
      end
   end
endmodule // pwsq_idle

/* src/pwsq_top.sv */
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// Functional notes
// - Power switch rising edge starts the power-on sequence.
// - Wake time equal to clock minutes powers on regardless of switch.
// - Power switch falling edge starts the power-off sequence.
// - Low battery interrupts the CPU and requests a 30 second warning.
// - After the warning, power goes off if the switch is still on.
// - Idle key-wait with no I/O powers off after the interval, default 10 min.
// - Interval is programmable 1 to 255 minutes and is used as written.
// - Power-off unloads the head and cuts peripheral unit power.
// - Power outputs change only after an interrupt service delay.
// - Logic power stays until I/O sequences finish; printer is reinitialised.
// - A committed power-off runs a save sequence with the CPU first.
// - Power-on output is active low.
// - Power-on enables logic supply and battery-backed supply together.
// - Battery select high picks auxiliary battery, low picks main.
// - Auxiliary battery kept during low battery so the warning shows.
// - Power-off stops logic supply and returns backup to normal.
// - Initialise strobe goes to the gate arrays.
// - Receivers use the strobe only as reset, never for power.
// - Gate-array initialise strobe is active low.
// - Active-low system reset holds the processors.
module pwsq_top import pwsq_pkg::*; #(
   parameter int unsigned SEC_CYCLES = CLK_HZ
) (
   input  wire logic          i_clk,
   input  wire logic          i_sys_rst,
   input  wire pwsq_bus_req_s i_bus,
   output logic [DATA_W-1:0]  o_rdata,
   input  wire logic          i_power_switch_irq,
   input  wire logic          i_battery_low,
   input  wire logic          i_key_wait,
   input  wire logic          i_io_active,
   input  wire logic          i_mech_busy,
   input  wire logic          i_save_done,
   output logic               o_power_on_n,
   output logic               o_backup_rail_en,
   output logic               o_backup_batt_select,
   output logic               o_gate_array_init_n,
   output logic               o_system_reset_n,
   output logic               o_cpu_irq,
   output logic               o_warn_request,
   output logic               o_printer_init,
   output pwsq_periph_s       o_periph_off
);
   // Register address match, shared by read and write decode
   function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
      reg_hit = (a == off);
   endfunction

   pwsq_state_e      state;
   pwsq_state_e      next_state;
   logic [TMR_W-1:0] tmr;
   logic [SEC_W-1:0] warn_sec;
   logic             sw_prev;
   logic             off_req;
   logic             wake_en;
   logic             auto_en;
   logic [LIM_W-1:0] idle_lim;
   logic [MIN_W-1:0] wake_min;
   logic             lim_changed;
   logic [MIN_W-1:0] minutes;
   logic             sec_tick;
   logic             min_tick;
   logic             idle_timeout;

   // Bus decode
   wire wr_ctrl = i_bus.wr && reg_hit(i_bus.addr, REG_CTRL);
   wire wr_idle = i_bus.wr && reg_hit(i_bus.addr, REG_IDLE);
   wire wr_wake = i_bus.wr && reg_hit(i_bus.addr, REG_WAKE);
   wire wr_time = i_bus.wr && reg_hit(i_bus.addr, REG_TIME);
   // Limit field; zero would wrap the count to a 256-minute timeout
   wire [LIM_W-1:0] wr_lim = i_bus.wdata[LIM_W-1:0];
   wire lim_ok = (wr_lim != '0);   // Zero is outside 1..255 and is ignored

   // Switch edges; inputs are already synchronous
   wire sw_rise = i_power_switch_irq && !sw_prev;
   wire sw_fall = !i_power_switch_irq && sw_prev;

   // Wake alarm fires once, on the minute the clock reaches the set time
   wire wake_hit = wake_en && min_tick && (minutes == wake_min);

   // Step ends and off triggers; save also waits for mechanics
   wire tmr_svc  = (tmr == SVC_LAST);
   wire tmr_rst  = (tmr == RESET_LAST);
   wire tmr_init = (tmr == INIT_LAST);
   wire warn_done = sec_tick && (warn_sec == WARN_LAST);
   wire off_now  = sw_fall || off_req || (auto_en && idle_timeout);
   wire save_ok  = i_save_done && !i_mech_busy;

   // Idle timer runs only while powered and waiting for keys
   wire idle_en      = (state == PWSQ_RUN) && i_key_wait && !i_io_active;
   wire idle_restart = i_io_active || lim_changed || (state != PWSQ_RUN);

   // Next sequencer state
   always_comb begin
      next_state = state;
      case (state)
         PWSQ_OFF: begin
            if (sw_rise || wake_hit) next_state = PWSQ_ON_SVC;
         end
         PWSQ_ON_SVC: begin
            if (tmr_svc) next_state = PWSQ_PWR_UP;
         end
         PWSQ_PWR_UP: begin
            if (tmr_rst) next_state = PWSQ_RUN;
         end
         PWSQ_RUN: begin
            if (off_now) next_state = PWSQ_OFF_SVC;
            else if (i_battery_low) next_state = PWSQ_WARN;
         end
         PWSQ_WARN: begin
            if (sw_fall) next_state = PWSQ_OFF_SVC;
            else if (warn_done && i_power_switch_irq) next_state = PWSQ_OFF_SVC;
         end
         PWSQ_OFF_SVC: begin
            if (tmr_svc) next_state = PWSQ_SAVE;
         end
         PWSQ_SAVE: begin
            if (save_ok) next_state = PWSQ_INIT;
         end
         PWSQ_INIT: begin
            if (tmr_init) next_state = PWSQ_OFF;
         end
         default: next_state = PWSQ_OFF;
      endcase
   end

   // Switch still on when the warning ends: power goes off
   warn_auto_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (state == PWSQ_WARN) && warn_done && i_power_switch_irq |=> (state == PWSQ_OFF_SVC))
      else $error("warning end did not power off");
   // Switch already off: the warning stays, power is not cut here
   warn_stay_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (state == PWSQ_WARN) && warn_done && !i_power_switch_irq && !sw_fall
      |=> (state == PWSQ_WARN))
      else $error("warning left with switch off");

   // Output levels derived from the coming state so each output is a flop
   wire next_on     = (next_state != PWSQ_OFF) && (next_state != PWSQ_ON_SVC);
   wire next_rel    = (next_state == PWSQ_RUN) || (next_state == PWSQ_WARN) ||
                      (next_state == PWSQ_OFF_SVC) || (next_state == PWSQ_SAVE);
   wire next_init   = (next_state == PWSQ_PWR_UP) || (next_state == PWSQ_INIT);
   wire next_irq    = (next_state == PWSQ_WARN) || (next_state == PWSQ_OFF_SVC) ||
                      (next_state == PWSQ_SAVE);
   wire next_warn   = (next_state == PWSQ_WARN);
   wire next_periph = !next_rel;
   wire next_pinit  = (state == PWSQ_SAVE) && (next_state == PWSQ_INIT);
   // Auxiliary battery carries the display through the warning and the first off-service cycle
   wire next_aux    = next_warn || ((state == PWSQ_WARN) && next_irq);

   // Step timer restarts on every state change
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state    <= PWSQ_OFF;
         tmr      <= '0;
         warn_sec <= '0;
         sw_prev  <= 1'b0;
      end else begin
         state    <= next_state;
         tmr      <= (next_state != state) ? '0 : TMR_W'(tmr + 1'b1);
         warn_sec <= (state != PWSQ_WARN) ? '0 :
                     (sec_tick ? SEC_W'(warn_sec + 1'b1) : warn_sec);
         sw_prev  <= i_power_switch_irq;
      end
   end

   // Pin outputs; power-on drives logic and backed supplies together
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_power_on_n         <= 1'b1;
         o_backup_rail_en     <= 1'b0;
         o_backup_batt_select <= 1'b0;
         o_gate_array_init_n  <= 1'b0;
         o_system_reset_n     <= 1'b0;
         o_cpu_irq            <= 1'b0;
         o_warn_request       <= 1'b0;
         o_printer_init       <= 1'b0;
         o_periph_off         <= '1;
      end else begin
         o_power_on_n         <= !next_on;
         o_backup_rail_en     <= next_on;
         o_backup_batt_select <= next_aux;
         o_gate_array_init_n  <= !next_init;
         o_system_reset_n     <= next_rel;
         o_cpu_irq            <= next_irq;
         o_warn_request       <= next_warn;
         o_printer_init       <= next_pinit;
         o_periph_off         <= {$bits(pwsq_periph_s){next_periph}};
      end
   end

   // Processors held and supply off while idle
   rst_off_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (state == PWSQ_OFF) |-> !o_system_reset_n && o_power_on_n)
      else $error("off state with processors live");
   // Power-up initialises the gate arrays under a live supply
   init_pwrup_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (state == PWSQ_PWR_UP) |-> !o_gate_array_init_n && !o_power_on_n)
      else $error("no initialise at power up");
   // Strobe is a reset only; supply stays on while it is low
   strobe_power_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (state == PWSQ_INIT) |-> !o_gate_array_init_n && !o_power_on_n && o_backup_rail_en)
      else $error("initialise strobe gated supply");
   // Save runs with processors live and the CPU interrupted
   save_live_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (state == PWSQ_SAVE) |-> o_cpu_irq && o_system_reset_n)
      else $error("save without live processors");
   // Auxiliary battery carries the display through the warning
   batt_warn_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (state == PWSQ_WARN) |-> o_backup_batt_select && o_warn_request)
      else $error("warning on main battery");
   // Backup back to the main battery once off
   batt_off_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (state == PWSQ_OFF) |-> !o_backup_batt_select && !o_backup_rail_en)
      else $error("backup not normal when off");
   // One printer pulse, still under logic power
   printer_pulse_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_printer_init |=> !o_printer_init && !o_power_on_n)
      else $error("printer pulse malformed");

   // Software registers; power-off request is a one-cycle self-clearing bit
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         off_req     <= 1'b0;
         wake_en     <= WAKE_EN_RST;
         auto_en     <= AUTO_EN_RST;
         idle_lim    <= IDLE_DEF_MIN;
         wake_min    <= '0;
         lim_changed <= 1'b0;
      end else begin
         off_req     <= wr_ctrl && i_bus.wdata[CTRL_OFF_REQ];
         lim_changed <= wr_idle && lim_ok;
         if (wr_ctrl) begin
            wake_en <= i_bus.wdata[CTRL_WAKE_EN];
            auto_en <= i_bus.wdata[CTRL_AUTO_EN];
         end
         if (wr_idle && lim_ok) idle_lim <= wr_lim;
         if (wr_wake) wake_min <= i_bus.wdata[MIN_W-1:0];
      end
   end

   // A zero limit must leave the setting alone
   lim_keep_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_idle && !lim_ok |=> $stable(idle_lim))
      else $error("zero idle limit taken");
   // A legal limit is used as written
   lim_set_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_idle && lim_ok |=> (idle_lim == $past(wr_lim)))
      else $error("idle limit not stored");

   // Read mux; unmapped addresses read zero
   wire [DATA_W-1:0] status_word = DATA_W'({state, 1'b0, i_power_switch_irq,
                                           o_backup_batt_select, !o_power_on_n});
   wire [DATA_W-1:0] rd_mux =
      reg_hit(i_bus.addr, REG_CTRL)   ? DATA_W'({auto_en, wake_en, 1'b0}) :
      reg_hit(i_bus.addr, REG_STATUS) ? status_word :
      reg_hit(i_bus.addr, REG_IDLE)   ? DATA_W'(idle_lim) :
      reg_hit(i_bus.addr, REG_WAKE)   ? DATA_W'(wake_min) :
      reg_hit(i_bus.addr, REG_TIME)   ? DATA_W'(minutes) : '0;

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) o_rdata <= '0;
      else o_rdata <= i_bus.rd ? rd_mux : '0;
   end

   pwsq_rtc #(
      .SEC_CYCLES (SEC_CYCLES)
   ) u_rtc (
      .i_clk        (i_clk),
      .i_sys_rst    (i_sys_rst),
      .i_time_wr    (wr_time),
      .i_time_wdata (i_bus.wdata[MIN_W-1:0]),
      .o_minutes    (minutes),
      .o_sec_tick   (sec_tick),
      .o_min_tick   (min_tick)
   );

   // Minute ticks advance the idle count; I/O or a new limit restarts it
   pwsq_idle u_idle (
      .i_clk      (i_clk),
      .i_sys_rst  (i_sys_rst),
      .i_restart  (idle_restart),
      .i_count_en (idle_en),
      .i_min_tick (min_tick),
      .i_limit    (idle_lim),
      .o_timeout  (idle_timeout)
   );

   // Minute ticks fall on second ticks, so idle counts clock minutes
   min_tick_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      min_tick |-> sec_tick)
      else $error("minute tick off a second");
   // A restart blocks a timeout in the next cycle
   idle_restart_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      idle_restart |=> !idle_timeout)
      else $error("timeout despite restart");

   // Checks
   localparam int ON_BOUND = 40;

   sw_on_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (state == PWSQ_OFF) && sw_rise |-> ##[1:ON_BOUND] !o_power_on_n)
      else $error("switch on did not power up");
   wake_on_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (state == PWSQ_OFF) && wake_hit |=> (state == PWSQ_ON_SVC))
      else $error("wake alarm ignored");
   sw_off_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (state == PWSQ_RUN) && sw_fall |=> (state == PWSQ_OFF_SVC) && o_cpu_irq)
      else $error("switch off not handled");
   lowbat_warn_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (state == PWSQ_RUN) && i_battery_low && !off_now
      |=> o_warn_request && o_cpu_irq && o_backup_batt_select)
      else $error("low battery warning missing");
   warn_end_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (state == PWSQ_WARN) && !sw_fall && !warn_done |=> (state == PWSQ_WARN))
      else $error("warning cut short");
   idle_off_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (state == PWSQ_RUN) && auto_en && idle_timeout |=> (state == PWSQ_OFF_SVC))
      else $error("idle timeout ignored");
   periph_cut_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      $rose(o_power_on_n) |-> (o_periph_off == '1) && !o_system_reset_n)
      else $error("peripherals powered at power off");
   svc_lag_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      $fell(o_power_on_n) |-> ($past(state) == PWSQ_ON_SVC))
      else $error("power on without service delay");
   save_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (state == PWSQ_SAVE) && !save_ok |=> (state == PWSQ_SAVE) && !o_power_on_n)
      else $error("power removed during I/O");
   init_strobe_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      $rose(o_power_on_n) |-> $past(!o_gate_array_init_n))
      else $error("gate arrays not initialised before power off");

   cov_lowbat_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
      (state == PWSQ_WARN) ##1 (state == PWSQ_OFF_SVC));
   cov_wake_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
      (state == PWSQ_OFF) && wake_hit);
   cov_idle_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
      (state == PWSQ_RUN) && idle_timeout);
   cov_warn_hold_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
      (state == PWSQ_WARN) && warn_done && !i_power_switch_irq);
   cov_save_wait_c: cover property (@(posedge i_clk) disable iff (i_sys_rst)
      (state == PWSQ_SAVE) && i_mech_busy);
endmodule // pwsq_top

/* bench/pwsq_host_model.sv */
`timescale 1ns/1ps
module pwsq_host_model import pwsq_pkg::*; (
   input  wire logic       i_clk,
   input  wire logic       i_cpu_irq,
   input  wire logic       i_system_reset_n,
   input  wire logic [7:0] i_busy_len,
   output logic            o_mech_busy,
   output logic            o_save_done
);
   logic [7:0] left;
   logic       irq_q;
   initial begin
      left = 8'h00;
      irq_q = 1'b0;
      o_mech_busy = 1'b0;
      o_save_done = 1'b0;
   end
   // An interrupt starts a mechanical run; save is reported only after it ends
   always @(posedge i_clk) begin
      irq_q <= i_cpu_irq;
      if (!i_system_reset_n) begin
         o_save_done <= 1'b0;
         o_mech_busy <= 1'b0;
      end else if (i_cpu_irq && !irq_q) begin
         o_mech_busy <= 1'b1;
         left <= i_busy_len;
      end else if (left != 8'h00) begin
         left <= left - 8'h01;
      end else if (o_mech_busy) begin
         o_mech_busy <= 1'b0;
         o_save_done <= 1'b1;
      end
   end
endmodule // pwsq_host_model

/* bench/power_on_off_sequencer_tb_top.sv */
`timescale 1ns/1ps
module power_on_off_sequencer_tb_top import pwsq_pkg::*;;
   localparam int unsigned SEC = 10; // Short second keeps the run brief
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] exp;
   } pwsq_row_s;
   logic              clk, rst, sw, low, kw, ioa, mech, saved;
   logic              pon_n, bk_en, bsel, ga_n, rst_n, irq, warn, pinit;
   pwsq_bus_req_s     bus;
   pwsq_periph_s      poff;
   logic [DATA_W-1:0] rdata, rd;
   logic [7:0]        busy_len;
   int                fail_count, checked, n, pinit_cnt, p0;
   pwsq_row_s         rows [4];

   pwsq_top #(.SEC_CYCLES(SEC)) dut_u (.i_clk(clk), .i_sys_rst(rst), .i_bus(bus),
      .o_rdata(rdata), .i_power_switch_irq(sw), .i_battery_low(low), .i_key_wait(kw),
      .i_io_active(ioa), .i_mech_busy(mech), .i_save_done(saved), .o_power_on_n(pon_n),
      .o_backup_rail_en(bk_en), .o_backup_batt_select(bsel), .o_gate_array_init_n(ga_n),
      .o_system_reset_n(rst_n), .o_cpu_irq(irq), .o_warn_request(warn),
      .o_printer_init(pinit), .o_periph_off(poff));
   pwsq_host_model host_u (.i_clk(clk), .i_cpu_irq(irq), .i_system_reset_n(rst_n),
      .i_busy_len(busy_len), .o_mech_busy(mech), .o_save_done(saved));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Printer pulses are one cycle, so they are counted rather than sampled
   always @(posedge clk) if (pinit === 1'b1) pinit_cnt++;

   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_word({31'h0, got}, {31'h0, exp});
   endtask
   task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk) bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk) bus <= '0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clk) bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge clk) bus <= '0;
      #1 d = rdata;
   endtask
   function automatic logic sel(input int w);
      case (w)
         0: sel = pon_n;
         1: sel = rst_n;
         default: sel = irq;
      endcase
   endfunction
   // Bounded wait; n holds the cycles it took
   task automatic wait_for(input int w, input logic v, input int max);
      n = 0;
      while (sel(w) !== v && n < max) begin
         @(posedge clk);
         #1 n++;
      end
      chk_bit(sel(w), v);
   endtask
   task automatic cycles(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic power_up();
      @(posedge clk) sw <= 1'b1;
      wait_for(1, 1'b1, 80);
   endtask

   initial begin
      #200000;
      fail_count++;
      close_out();
   end

   initial begin
      bus = '0;
      {sw, low, kw, ioa, rst} = 5'h01;
      busy_len = 8'h32;
      {fail_count, checked, pinit_cnt} = '0;
      rows = '{'{REG_IDLE, 32'h0000000a}, '{REG_CTRL, 32'h00000004},
               '{REG_STATUS, 32'h00000000}, '{8'h14, 32'h00000000}};
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      #1 chk_bit(pon_n, 1'b1);
      chk_bit(bk_en, 1'b0);
      chk_bit(ga_n, 1'b0);
      chk_bit(rst_n, 1'b0);
      chk_bit(bsel, 1'b0);
      chk_word(32'(poff), 32'h0000003f);
      foreach (rows[i]) begin
         bus_rd(rows[i].addr, rd);
         chk_word(rd, rows[i].exp);
      end
      $display("test reset and registers done");
      // Switch on: output lags the service delay, then reset releases
      @(posedge clk) sw <= 1'b1;
      wait_for(0, 1'b0, 40);
      chk_bit(n >= SVC_CYC, 1'b1);
      chk_bit(bk_en, 1'b1);
      chk_bit(rst_n, 1'b0);
      chk_bit(ga_n, 1'b0);
      wait_for(1, 1'b1, 40);
      chk_bit(n >= RESET_CYC - 1, 1'b1);
      chk_bit(ga_n, 1'b1);
      chk_word(32'(poff), 32'h00000000);
      $display("test switch on done");
      // Switch off with a slow mechanical run on the far side
      p0 = pinit_cnt;
      @(posedge clk) sw <= 1'b0;
      wait_for(2, 1'b1, 5);
      chk_bit(rst_n, 1'b1);
      cycles(40);
      chk_bit(pon_n, 1'b0);
      wait_for(0, 1'b1, 200);
      chk_word(pinit_cnt, p0 + 1);
      chk_word(32'(poff), 32'h0000003f);
      chk_bit(bk_en, 1'b0);
      $display("test switch off done");
      // Low battery with the switch on: warning, then automatic off
      power_up();
      @(posedge clk) low <= 1'b1;
      wait_for(2, 1'b1, 5);
      chk_bit(warn, 1'b1);
      chk_bit(bsel, 1'b1);
      wait_for(0, 1'b1, WARN_SEC * SEC + 200);
      chk_bit(n >= WARN_SEC * SEC - 10, 1'b1);
      chk_bit(bsel, 1'b0);
      @(posedge clk) low <= 1'b0;
      sw <= 1'b0;
      $display("test low battery done");
      // Idle timeout: zero is refused, I/O activity holds the count back
      bus_wr(REG_IDLE, 32'h00000001);
      bus_wr(REG_IDLE, 32'h00000000);
      bus_rd(REG_IDLE, rd);
      chk_word(rd, 32'h00000001);
      @(posedge clk) kw <= 1'b1;
      ioa <= 1'b1;
      power_up();
      cycles(3 * SEC_PER_MIN * SEC);
      chk_bit(pon_n, 1'b0);
      @(posedge clk) ioa <= 1'b0;
      wait_for(0, 1'b1, 2 * SEC_PER_MIN * SEC + 200);
      @(posedge clk) kw <= 1'b0;
      sw <= 1'b0;
      $display("test idle timeout done");
      // Wake alarm with the switch off, then low battery must not switch off
      bus_wr(REG_TIME, 32'h00000005);
      bus_wr(REG_WAKE, 32'h00000006);
      bus_wr(REG_CTRL, 32'h00000006);
      wait_for(0, 1'b0, SEC_PER_MIN * SEC + 100);
      @(posedge clk) low <= 1'b1;
      cycles(WARN_SEC * SEC + 100);
      chk_bit(pon_n, 1'b0);
      bus_rd(REG_STATUS, rd);
      chk_word(rd, 32'h00000043);
      @(posedge clk) rst <= 1'b1;
      low <= 1'b0;
      cycles(3);
      chk_bit(pon_n, 1'b1);
      chk_bit(rst_n, 1'b0);
      @(posedge clk) rst <= 1'b0;
      cycles(2);
      chk_bit(pon_n, 1'b1);
      bus_rd(REG_CTRL, rd);
      chk_word(rd, 32'h00000004);
      bus_rd(REG_IDLE, rd);
      chk_word(rd, 32'h0000000a);
      $display("test wake and second reset done");
      close_out();
   end
endmodule // power_on_off_sequencer_tb_top
